// ===== flash_self_program_sequencer_tb_top.sv
// Self-checking testbench for the flash self-program sequencer
`timescale 1ns/1ps
`default_nettype none
module flash_self_program_sequencer_tb_top;
  typedef struct packed {
    logic        boot;
    logic [2:0]  op;
    logic [13:0] a;
    logic [7:0]  d;
    logic        ign;
    logic [7:0]  x;
  } fsps_row_t;
  logic aclk = 1'b0, aresetn = 1'b0, slow = 1'b0, cpu_in_boot = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, low_bound_opt = 8'h30, arr_rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [3:0] boot_size_opt = 4'h2, wstrb = 4'hF;
  logic [1:0] bresp, rresp, r;
  logic awready, wready, bvalid, arready, rvalid, cpu_halt, arr_req, arr_ack;
  fsps_pkg::fsps_arr_cmd_t arr_cmd;
  int failures = 0, num_checks = 0;
  fsps_row_t rows [12] = '{
    '{1'b0, fsps_pkg::OP_PROG, 14'h3010, 8'h5A, 1'b0, 8'h5A},
    '{1'b0, fsps_pkg::OP_READ, 14'h3010, 8'h00, 1'b0, 8'h5A},
    '{1'b0, fsps_pkg::OP_PROG, 14'h3010, 8'hF0, 1'b0, 8'hF0},
    '{1'b0, fsps_pkg::OP_READ, 14'h3010, 8'h00, 1'b0, 8'h50},
    '{1'b0, fsps_pkg::OP_ERASE, 14'h3000, 8'h00, 1'b0, 8'h00},
    '{1'b0, fsps_pkg::OP_READ, 14'h3010, 8'h00, 1'b0, 8'hFF},
    '{1'b0, fsps_pkg::OP_PROG, 14'h1000, 8'h12, 1'b1, 8'h12},
    '{1'b0, fsps_pkg::OP_READ, 14'h1000, 8'h00, 1'b0, 8'hFF},
    '{1'b1, fsps_pkg::OP_PROG, 14'h1000, 8'h12, 1'b0, 8'h12},
    '{1'b0, fsps_pkg::OP_READ, 14'h1000, 8'h00, 1'b0, 8'h12},
    '{1'b0, fsps_pkg::OP_PROG, 14'h3C00, 8'h00, 1'b1, 8'h00},
    '{1'b1, fsps_pkg::OP_ERASE, 14'h3C00, 8'h00, 1'b1, 8'h00}};
  fsps_flash_seq u_fsps_flash_seq (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .cpu_in_boot(cpu_in_boot),
    .boot_size_opt(boot_size_opt), .low_bound_opt(low_bound_opt),
    .cpu_halt(cpu_halt), .arr_cmd(arr_cmd), .arr_req(arr_req),
    .arr_ack(arr_ack), .arr_rdata(arr_rdata));
  fsps_flash_model u_fsps_flash_model (
    .aclk(aclk), .slow(slow), .arr_cmd(arr_cmd), .arr_req(arr_req),
    .arr_ack(arr_ack), .arr_rdata(arr_rdata));
  // Clock at 100 MHz
  initial begin
    forever #5 aclk = ~aclk;
  end
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task final_report;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Bus write: address and data offered together, each released when taken
  task axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic pa, pw, pb, ta, tw, tb;
    pa = 1'b1;
    pw = 1'b1;
    pb = 1'b1;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (pa || pw || pb) begin
      @(negedge aclk);
      ta = pa && awready;
      tw = pw && wready;
      tb = pb && bvalid;
      if (tb) rs = bresp;
      @(posedge aclk);
      if (ta) begin awvalid <= 1'b0; pa = 1'b0; end
      if (tw) begin wvalid <= 1'b0; pw = 1'b0; end
      if (tb) begin bready <= 1'b0; pb = 1'b0; end
    end
  endtask
  // Bus read: rready held until the answer arrives
  task axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic pa, pr, ta, tr;
    pa = 1'b1;
    pr = 1'b1;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (pa || pr) begin
      @(negedge aclk);
      ta = pa && arready;
      tr = pr && rvalid;
      if (tr) begin v = rdata; rs = rresp; end
      @(posedge aclk);
      if (ta) begin arvalid <= 1'b0; pa = 1'b0; end
      if (tr) begin rready <= 1'b0; pr = 1'b0; end
    end
  endtask
  // Set up an operation and send the unlock pair
  task trig(input logic en, input logic [2:0] op, input logic [13:0] a,
            input logic [7:0] dv, input logic [7:0] b2);
    axw(fsps_pkg::OFF_CTRL, {24'h0, en, 7'h0}, r);
    axw(fsps_pkg::OFF_MODE, {29'h0, op}, r);
    axw(fsps_pkg::OFF_ADRH, {26'h0, a[13:8]}, r);
    axw(fsps_pkg::OFF_ADRL, {24'h0, a[7:0]}, r);
    axw(fsps_pkg::OFF_DATA, {24'h0, dv}, r);
    axw(fsps_pkg::OFF_UNLK, {24'h0, fsps_pkg::UNLK_FIRST}, r);
    axw(fsps_pkg::OFF_UNLK, {24'h0, b2}, r);
  endtask
  // Halt state right after the trigger, then bounded wait for completion
  task hold_chk(input logic exp);
    int n;
    n = 0;
    #1 chk("cpu_halt", {31'h0, cpu_halt}, {31'h0, exp});
    while (cpu_halt !== 1'b0 && n < 60) begin
      @(posedge aclk);
      #1 n++;
    end
    chk("halt_end", {31'h0, cpu_halt}, 32'h0);
  endtask
  // Erase commands must carry a page-aligned address
  always @(negedge aclk) begin
    if (arr_req === 1'b1 && arr_cmd.op === fsps_pkg::FSPS_ARR_ER) begin
      chk("erase_addr", {23'h0, arr_cmd.addr[8:0]}, 32'h0);
    end
  end
  // Watchdog against a hung handshake
  initial begin
    #300000;
    failures++;
    final_report;
  end
  // Main sequence
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axr(fsps_pkg::OFF_STAT, d, r);
    chk("status_rst", {24'h0, d[7:0]}, 32'h20);
    for (int i = 0; i < 12; i++) begin
      cpu_in_boot <= rows[i].boot;
      slow <= i[0];
      trig(1'b1, rows[i].op, rows[i].a, rows[i].d, fsps_pkg::UNLK_SECOND);
      hold_chk(!rows[i].ign);
      axr(fsps_pkg::OFF_STAT, d, r);
      chk("ignored", {31'h0, d[1]}, {31'h0, rows[i].ign});
      axr(fsps_pkg::OFF_DATA, d, r);
      chk("data", {24'h0, d[7:0]}, {24'h0, rows[i].x});
      axw(fsps_pkg::OFF_MODE, {29'h0, fsps_pkg::OP_STBY}, r);
      axw(fsps_pkg::OFF_CTRL, 32'h0, r);
      $display("row %0d done", i);
    end
    // A write with lane 0 strobe low must leave the data byte alone
    wstrb <= 4'h0;
    axw(fsps_pkg::OFF_DATA, 32'hAB, r);
    wstrb <= 4'hF;
    axr(fsps_pkg::OFF_DATA, d, r);
    chk("strobe_off", {24'h0, d[7:0]}, 32'h0);
    cpu_in_boot <= 1'b0;
    trig(1'b1, fsps_pkg::OP_PROG, 14'h3020, 8'h00, 8'h00);
    axw(fsps_pkg::OFF_UNLK, {24'h0, fsps_pkg::UNLK_SECOND}, r);
    hold_chk(1'b0);
    axw(fsps_pkg::OFF_UNLK, {24'h0, fsps_pkg::UNLK_FIRST}, r);
    axw(fsps_pkg::OFF_DATA, 32'h0, r);
    axw(fsps_pkg::OFF_UNLK, {24'h0, fsps_pkg::UNLK_SECOND}, r);
    hold_chk(1'b0);
    trig(1'b0, fsps_pkg::OP_PROG, 14'h3020, 8'h00, fsps_pkg::UNLK_SECOND);
    hold_chk(1'b0);
    trig(1'b1, fsps_pkg::OP_STBY, 14'h3020, 8'h00, fsps_pkg::UNLK_SECOND);
    hold_chk(1'b0);
    trig(1'b1, 3'h5, 14'h3020, 8'h00, fsps_pkg::UNLK_SECOND);
    hold_chk(1'b0);
    $display("unlock and enable test done");
    axr(8'h40, d, r);
    chk("rresp_unmapped", {30'h0, r}, {30'h0, fsps_pkg::RESP_DECERR});
    axw(8'h40, 32'h0, r);
    chk("bresp_unmapped", {30'h0, r}, {30'h0, fsps_pkg::RESP_DECERR});
    axw(fsps_pkg::OFF_LOWB, 32'h20, r);
    chk("bresp_okay", {30'h0, r}, {30'h0, fsps_pkg::RESP_OKAY});
    trig(1'b1, fsps_pkg::OP_PROG, 14'h2100, 8'h77, fsps_pkg::UNLK_SECOND);
    hold_chk(1'b1);
    $display("bus and low bound test done");
    @(posedge aclk);
    aresetn <= 1'b0;
    boot_size_opt <= 4'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axr(fsps_pkg::OFF_STAT, d, r);
    chk("status_off", {24'h0, d[7:0]}, 32'h00);
    trig(1'b1, fsps_pkg::OP_PROG, 14'h3C00, 8'h00, fsps_pkg::UNLK_SECOND);
    hold_chk(1'b1);
    $display("reset test done");
    final_report;
  end
endmodule
`default_nettype wire

// ===== fsps_flash_model.sv
// Behavioural model of the embedded flash array behind the sequencer
`timescale 1ns/1ps
`default_nettype none
module fsps_flash_model (
  input  wire logic                    aclk,
  input  wire logic                    slow,
  input  wire fsps_pkg::fsps_arr_cmd_t arr_cmd,
  input  wire logic                    arr_req,
  output logic                         arr_ack,
  output logic [7:0]                   arr_rdata
);
  logic [7:0] mem [0:16383];
  logic [2:0] cnt;
  // Array starts fully erased
  initial begin
    for (int i = 0; i < 16384; i++) begin
      mem[i] = 8'hFF;
    end
    arr_ack = 1'b0;
    arr_rdata = 8'h00;
    cnt = 3'h0;
  end
  // Serve one command per request, promptly or after a few cycles
  always @(posedge aclk) begin
    arr_ack <= 1'b0;
    arr_rdata <= ~arr_rdata; // Read bus not held outside an answer
    if (arr_req && !arr_ack) begin
      if (cnt < (slow ? 3'h4 : 3'h0)) begin
        cnt <= cnt + 3'h1;
      end else begin
        cnt <= 3'h0;
        arr_ack <= 1'b1;
        case (arr_cmd.op)
          fsps_pkg::FSPS_ARR_RD: arr_rdata <= mem[arr_cmd.addr];
          fsps_pkg::FSPS_ARR_WR: mem[arr_cmd.addr] <= mem[arr_cmd.addr] & arr_cmd.data;
          default: begin
            for (int j = 0; j < 512; j++) begin
              mem[{arr_cmd.addr[13:9], j[8:0]}] <= 8'hFF;
            end
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ===== fsps_flash_seq.sv
// Flash self-program sequencer with AXI4-Lite register slave
// What this block does
// - Operation code 011 at trigger performs a page erase.
// - Operation code 010 at trigger programs one byte.
// - Operation code 001 at trigger reads one byte.
// - Start only after 0x46 then 0xB9 written back to back to unlock.
// - Program writes the data register byte to the addressed location.
// - Read completion loads the addressed byte into the data register.
// - Programming can only clear bits; ones need an erase.
// - Page erase sets every bit of the page to one.
// - Erase page is 512 bytes; address bits 8..0 are zero.
// - Processor halts from trigger until the operation completes.
// - Boot code may modify application and data; application only data.
// - Boot region size by option: off or 0.5K..7.5K in 0.5K steps.
// - Data region spans low bound register up to boot region start.
// - Low bound set by option or by software in the application region.
// - Target beyond the data region's last byte: trigger ignored.
//
// The address map and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module fsps_flash_seq #(
  parameter int ADDR_W = 14
) (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [7:0]             awaddr,
  input  wire logic                   awvalid,
  output logic                        awready,
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  input  wire logic                   wvalid,
  output logic                        wready,
  output logic [1:0]                  bresp,
  output logic                        bvalid,
  input  wire logic                   bready,
  input  wire logic [7:0]             araddr,
  input  wire logic                   arvalid,
  output logic                        arready,
  output logic [31:0]                 rdata,
  output logic [1:0]                  rresp,
  output logic                        rvalid,
  input  wire logic                   rready,
  input  wire logic                   cpu_in_boot,
  input  wire logic [3:0]             boot_size_opt,
  input  wire logic [7:0]             low_bound_opt,
  output logic                        cpu_halt,
  output fsps_pkg::fsps_arr_cmd_t     arr_cmd,
  output logic                        arr_req,
  input  wire logic                   arr_ack,
  input  wire logic [7:0]             arr_rdata
);
  typedef enum {ST_IDLE, ST_READ, ST_PGM_RD, ST_PGM_WR, ST_ERASE} fsps_state_t;
  fsps_state_t        state;
  logic [7:0]         ctrl, mode, adrh, adrl, data_byte, lowb, old_byte;
  logic [7:0]         aw_addr, w_byte;
  logic [3:0]         boot_size;
  logic               opt_loaded, armed, last_ignored, tgt_boot;
  logic               aw_full, w_full, w_lane0, wr_fire, unlk_wr;
  logic               trig_try, trig_ok, addr_ok;
  logic [2:0]         op_sel;
  logic [ADDR_W-1:0]  tgt;
  logic [ADDR_W:0]    boot_start, low_addr;
  // True when a is inside [lo, hi)
  function automatic logic in_window(input logic [ADDR_W:0] a,
                                     input logic [ADDR_W:0] lo,
                                     input logic [ADDR_W:0] hi);
    in_window = (a >= lo) && (a < hi);
  endfunction
  // Target address, region bounds and trigger qualification
  assign op_sel     = mode[fsps_pkg::OP_W-1:0];
  assign tgt        = ADDR_W'({adrh, adrl});
  assign boot_start = (ADDR_W+1)'(1 << ADDR_W)
                    - (ADDR_W+1)'({boot_size, {fsps_pkg::PAGE_BITS{1'b0}}});
  assign low_addr   = (ADDR_W+1)'({lowb, {fsps_pkg::LOWB_SHIFT{1'b0}}});
  assign addr_ok    = cpu_in_boot || (op_sel == fsps_pkg::OP_READ)
                    ? ({1'b0, tgt} < boot_start)
                    : in_window({1'b0, tgt}, low_addr, boot_start);
  assign wr_fire    = aw_full && w_full && !bvalid;
  assign unlk_wr    = wr_fire && (aw_addr == fsps_pkg::OFF_UNLK) && w_lane0;
  assign trig_try   = unlk_wr && armed && (w_byte == fsps_pkg::UNLK_SECOND);
  assign trig_ok    = trig_try && ctrl[fsps_pkg::CTRL_EN_BIT] && addr_ok
                    && (op_sel != fsps_pkg::OP_STBY)
                    && (op_sel <= fsps_pkg::OP_ERASE) && (state == ST_IDLE);
  assign cpu_halt   = (state != ST_IDLE);
  // AXI handshake readiness
  assign awready = !aw_full && !bvalid;
  assign wready  = !w_full && !bvalid;
  assign arready = !rvalid;
  // Write address and data capture, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full  <= 1'b0;
      aw_addr <= fsps_pkg::RST_BYTE;
      w_byte  <= fsps_pkg::RST_BYTE;
      w_lane0 <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_full <= 1'b1;
        aw_addr <= awaddr;
      end else if (wr_fire) begin
        aw_full <= 1'b0;
      end
      if (wvalid && wready) begin
        w_full  <= 1'b1;
        w_byte  <= wdata[7:0];
        w_lane0 <= wstrb[0];
      end else if (wr_fire) begin
        w_full <= 1'b0;
      end
    end
  end
  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= fsps_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp  <= (aw_addr <= fsps_pkg::OFF_STAT && aw_addr[1:0] == 2'h0)
              ? fsps_pkg::RESP_OKAY : fsps_pkg::RESP_DECERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end
  // Software-written control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= fsps_pkg::RST_BYTE;
      mode <= fsps_pkg::RST_BYTE;
      adrh <= fsps_pkg::RST_BYTE;
      adrl <= fsps_pkg::RST_BYTE;
    end else if (wr_fire && w_lane0) begin
      case (aw_addr)
        fsps_pkg::OFF_CTRL: ctrl <= w_byte;
        fsps_pkg::OFF_MODE: mode <= w_byte;
        fsps_pkg::OFF_ADRH: adrh <= w_byte;
        fsps_pkg::OFF_ADRL: adrl <= w_byte;
        default: ;
      endcase
    end
  end
  // Option straps caught after reset release; low bound also by software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      opt_loaded <= 1'b0;
      boot_size  <= 4'h0;
      lowb       <= fsps_pkg::RST_BYTE;
    end else if (!opt_loaded) begin
      opt_loaded <= 1'b1;
      boot_size  <= boot_size_opt;
      lowb       <= low_bound_opt;
    end else if (wr_fire && w_lane0 && aw_addr == fsps_pkg::OFF_LOWB
                 && !cpu_in_boot) begin
      lowb <= w_byte;
    end
  end
  // Unlock sequence tracking; any other write breaks the pair
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      armed <= 1'b0;
    end else if (wr_fire) begin
      armed <= unlk_wr && !armed && (w_byte == fsps_pkg::UNLK_FIRST);
    end
  end
  // Ignored-trigger status; accepted trigger clears it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_ignored <= 1'b0;
    end else if (trig_try) begin
      last_ignored <= !trig_ok;
    end
  end
  // Operation sequencer driving the flash array
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state    <= ST_IDLE;
      arr_req  <= 1'b0;
      arr_cmd  <= '0;
      tgt_boot <= 1'b0;
      old_byte <= fsps_pkg::RST_BYTE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (trig_ok) begin
            tgt_boot     <= cpu_in_boot;
            arr_req      <= 1'b1;
            arr_cmd.addr <= tgt;
            arr_cmd.data <= data_byte;
            case (op_sel)
              fsps_pkg::OP_READ: begin
                state       <= ST_READ;
                arr_cmd.op  <= fsps_pkg::FSPS_ARR_RD;
              end
              fsps_pkg::OP_PROG: begin
                state       <= ST_PGM_RD;
                arr_cmd.op  <= fsps_pkg::FSPS_ARR_RD;
              end
              default: begin
                state        <= ST_ERASE;
                arr_cmd.op   <= fsps_pkg::FSPS_ARR_ER;
                arr_cmd.addr <= {tgt[ADDR_W-1:fsps_pkg::PAGE_BITS],
                                 {fsps_pkg::PAGE_BITS{1'b0}}};
              end
            endcase
          end
        end
        ST_PGM_RD: begin
          if (arr_ack) begin
            state        <= ST_PGM_WR;
            old_byte     <= arr_rdata;
            arr_cmd.op   <= fsps_pkg::FSPS_ARR_WR;
            arr_cmd.data <= arr_rdata & arr_cmd.data;
          end
        end
        ST_READ, ST_PGM_WR, ST_ERASE: begin
          if (arr_ack) begin
            state   <= ST_IDLE;
            arr_req <= 1'b0;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
  // Data register: software writes, read results overwrite
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_byte <= fsps_pkg::RST_BYTE;
    end else if (state == ST_READ && arr_ack) begin
      data_byte <= arr_rdata;
    end else if (wr_fire && w_lane0 && aw_addr == fsps_pkg::OFF_DATA) begin
      data_byte <= w_byte;
    end
  end
  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= fsps_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp  <= fsps_pkg::RESP_OKAY;
      case (araddr)
        fsps_pkg::OFF_CTRL: rdata <= {24'h0, ctrl};
        fsps_pkg::OFF_MODE: rdata <= {24'h0, mode};
        fsps_pkg::OFF_ADRH: rdata <= {24'h0, adrh};
        fsps_pkg::OFF_ADRL: rdata <= {24'h0, adrl};
        fsps_pkg::OFF_DATA: rdata <= {24'h0, data_byte};
        fsps_pkg::OFF_UNLK: rdata <= 32'h0;
        fsps_pkg::OFF_LOWB: rdata <= {24'h0, lowb};
        fsps_pkg::OFF_STAT: rdata <= {24'h0, boot_size, 1'b0, armed,
                                      last_ignored, cpu_halt};
        default: begin
          rdata <= 32'h0;
          rresp <= fsps_pkg::RESP_DECERR;
        end
      endcase
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_trig;
    trig_ok;
  endsequence
  sequence s_op_done;
    arr_req && arr_ack && arr_cmd.op != fsps_pkg::FSPS_ARR_RD;
  endsequence
  property p_unlock_start;
    s_trig |=> cpu_halt && arr_req;
  endproperty
  a_unlock_start: assert property (p_unlock_start)
    else $error("trigger did not start operation");
  property p_need_enable;
    trig_try && !ctrl[fsps_pkg::CTRL_EN_BIT] |=> !cpu_halt && last_ignored;
  endproperty
  a_need_enable: assert property (p_need_enable)
    else $error("operation started while disabled");
  property p_read_loads;
    state == ST_READ && arr_ack |=> data_byte == $past(arr_rdata) && !cpu_halt;
  endproperty
  a_read_loads: assert property (p_read_loads)
    else $error("read byte not loaded");
  property p_prog_clears;
    state == ST_PGM_WR && arr_req |-> (arr_cmd.data & ~old_byte) == 8'h00;
  endproperty
  a_prog_clears: assert property (p_prog_clears)
    else $error("program would set a bit");
  property p_erase_align;
    arr_req && arr_cmd.op == fsps_pkg::FSPS_ARR_ER
      |-> arr_cmd.addr[fsps_pkg::PAGE_BITS-1:0] == '0;
  endproperty
  a_erase_align: assert property (p_erase_align)
    else $error("erase address not page aligned");
  property p_beyond;
    trig_try && {1'b0, tgt} >= boot_start |=> state == ST_IDLE ##1 !arr_req;
  endproperty
  a_beyond: assert property (p_beyond)
    else $error("trigger beyond data region accepted");
  property p_app_guard;
    arr_req && !tgt_boot && arr_cmd.op != fsps_pkg::FSPS_ARR_RD
      |-> {1'b0, arr_cmd.addr} >= low_addr;
  endproperty
  a_app_guard: assert property (p_app_guard)
    else $error("application code modified application region");
  property p_abort;
    unlk_wr && armed && w_byte != fsps_pkg::UNLK_SECOND |=> !armed ##1 !cpu_halt;
  endproperty
  a_abort: assert property (p_abort)
    else $error("partial unlock not discarded");
  property p_op_map;
    (s_trig and (op_sel == fsps_pkg::OP_ERASE)) |=> state == ST_ERASE;
  endproperty
  a_op_map: assert property (p_op_map)
    else $error("erase code did not select erase");
  property p_resume;
    s_op_done |=> !cpu_halt;
  endproperty
  a_resume: assert property (p_resume)
    else $error("halt not released after completion");
endmodule
`default_nettype wire

// ===== fsps_pkg.sv
// Constants and types shared by the flash self-program sequencer
`default_nettype none
package fsps_pkg;
  // Register byte offsets on the AXI4-Lite bus
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_ADRH = 8'h08;
  localparam logic [7:0] OFF_ADRL = 8'h0C;
  localparam logic [7:0] OFF_DATA = 8'h10;
  localparam logic [7:0] OFF_UNLK = 8'h14;
  localparam logic [7:0] OFF_LOWB = 8'h18;
  localparam logic [7:0] OFF_STAT = 8'h1C;
  // Field positions and reset values
  localparam int         CTRL_EN_BIT = 7;
  localparam int         OP_W        = 3;
  localparam logic [7:0] RST_BYTE    = 8'h00;
  // Operation select codes
  localparam logic [2:0] OP_STBY  = 3'h0;
  localparam logic [2:0] OP_READ  = 3'h1;
  localparam logic [2:0] OP_PROG  = 3'h2;
  localparam logic [2:0] OP_ERASE = 3'h3;
  // Unlock bytes
  localparam logic [7:0] UNLK_FIRST  = 8'h46;
  localparam logic [7:0] UNLK_SECOND = 8'hB9;
  // Flash geometry
  localparam int PAGE_BITS  = 9;
  localparam int LOWB_SHIFT = 8;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // Commands to the flash array
  typedef enum logic [1:0] {
    FSPS_ARR_RD,
    FSPS_ARR_WR,
    FSPS_ARR_ER
  } fsps_arr_op_t;
  typedef struct packed {
    fsps_arr_op_t op;
    logic [13:0]  addr;
    logic [7:0]   data;
  } fsps_arr_cmd_t;
endpackage
`default_nettype wire
